// >>> host_port_pkg.sv
// shared constants and types for the dual-style host bus port
package host_port_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int REG_DEPTH = 512;
  localparam int ADDR_HI = 8;
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_MUXED = 1'b1;
  localparam logic [2:0] SETUP_CYCLES = 3'h4;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_ACK = 2'b10
  } dev_state_type;

  typedef enum logic [4:0] {
    HOST_IDLE = 5'b00001,
    HOST_ADDR = 5'b00010,
    HOST_LATCH = 5'b00100,
    HOST_STROBE = 5'b01000,
    HOST_RELEASE = 5'b10000
  } host_state_type;
endpackage

// >>> host_bus_if.sv
// pin-level bus between the host processor and the device port
`timescale 1ns/1ns
interface host_bus_if;
  import host_port_pkg::*;
  logic bus_style_select;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_ad_out;
  logic host_ad_oe;
  logic [DATA_W-1:0] dev_ad_out;
  logic dev_ad_oe;
  logic ale;
  logic cs_n;
  logic transfer_strobe_n;
  logic dir_wr_n;
  logic ack_out;
  logic ack_oe;
  logic irq_out;
  logic irq_oe;
  logic [DATA_W-1:0] ad;
  logic transfer_ack_n;
  logic irq_request_n;

  // shared lines with pull-down, open-drain lines with pull-up
  assign ad = dev_ad_oe ? dev_ad_out : (host_ad_oe ? host_ad_out : DATA_RESET);
  assign transfer_ack_n = ack_oe ? ack_out : 1'b1;
  assign irq_request_n = irq_oe ? irq_out : 1'b1;

  modport device (
    input bus_style_select, addr, ad, ale, cs_n, transfer_strobe_n, dir_wr_n,
    output dev_ad_out, dev_ad_oe, ack_out, ack_oe, irq_out, irq_oe
  );
  modport host (
    input ad, transfer_ack_n, irq_request_n,
    output bus_style_select, addr, host_ad_out, host_ad_oe, ale, cs_n,
    output transfer_strobe_n, dir_wr_n
  );
endinterface

// >>> host_port_device.sv
// device end of the dual-style asynchronous host port with register file
// Functional notes
// - static select: low separate buses, high multiplexed
// - separate style: direction high reads, strobe qualifies
// - multiplexed: low address pins ignored, top bit used
// - multiplexed: strobe is read, direction is write
// - address selects exactly one register
// - multiplexed address latched on latch-strobe fall
// - chip select high ends cycle, floats data
// - open-drain acknowledge: data ready or write done
// - open-drain interrupt low while requests pending
`timescale 1ns/1ns
module host_port_device
  import host_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  host_bus_if.device bus,
  input wire logic irq_pending_in,
  output logic wr_strobe_out,
  output logic [ADDR_W-1:0] wr_addr_out,
  output logic [DATA_W-1:0] wr_data_out
);

  // two-stage synchronisers on every pin
  logic style_s1;
  logic style_s2;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic [DATA_W-1:0] ad_s1;
  logic [DATA_W-1:0] ad_s2;
  logic ale_s1;
  logic ale_s2;
  logic cs_s1;
  logic cs_s2;
  logic ds_s1;
  logic ds_s2;
  logic rw_s1;
  logic rw_s2;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      style_s1 <= STYLE_SEPARATE;
      style_s2 <= STYLE_SEPARATE;
      addr_s1 <= ADDR_RESET;
      addr_s2 <= ADDR_RESET;
      ad_s1 <= DATA_RESET;
      ad_s2 <= DATA_RESET;
      ale_s1 <= 1'b0;
      ale_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      ds_s1 <= 1'b1;
      ds_s2 <= 1'b1;
      rw_s1 <= 1'b1;
      rw_s2 <= 1'b1;
    end else begin
      style_s1 <= bus.bus_style_select;
      style_s2 <= style_s1;
      addr_s1 <= bus.addr;
      addr_s2 <= addr_s1;
      ad_s1 <= bus.ad;
      ad_s2 <= ad_s1;
      ale_s1 <= bus.ale;
      ale_s2 <= ale_s1;
      cs_s1 <= bus.cs_n;
      cs_s2 <= cs_s1;
      ds_s1 <= bus.transfer_strobe_n;
      ds_s2 <= ds_s1;
      rw_s1 <= bus.dir_wr_n;
      rw_s2 <= rw_s1;
    end
  end

  // register file
  logic [DATA_W-1:0] regs [REG_DEPTH];

  dev_state_type state;
  dev_state_type next_state;
  logic ale_prev;
  logic next_ale_prev;
  logic [ADDR_W-1:0] addr_latch;
  logic [ADDR_W-1:0] next_addr_latch;
  logic [DATA_W-1:0] ad_drive;
  logic [DATA_W-1:0] next_ad_drive;
  logic ad_oe;
  logic next_ad_oe;
  logic ack_oe;
  logic next_ack_oe;
  logic irq_oe;
  logic next_irq_oe;
  logic wr_strobe;
  logic next_wr_strobe;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] next_wr_data;

  logic strobe_active;
  logic is_read;
  logic [ADDR_W-1:0] target_addr;

  always_comb begin
    // strobe decoding by bus style
    if (style_s2 == STYLE_MUXED) begin
      strobe_active = ~ds_s2 | ~rw_s2;
      is_read = ~ds_s2;
      target_addr = addr_latch;
    end else begin
      strobe_active = ~ds_s2;
      is_read = rw_s2;
      target_addr = addr_s2;
    end
  end

  always_comb begin
    next_state = state;
    next_ale_prev = ale_s2;
    next_addr_latch = addr_latch;
    next_ad_drive = ad_drive;
    next_ad_oe = ad_oe;
    next_ack_oe = ack_oe;
    next_irq_oe = irq_pending_in;
    next_wr_strobe = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (ale_prev && !ale_s2) begin
      next_addr_latch = {addr_s2[ADDR_HI], ad_s2};
    end
    case (state)
      DEV_IDLE: begin
        next_ad_oe = 1'b0;
        next_ack_oe = 1'b0;
        if (!cs_s2 && strobe_active) begin
          next_state = DEV_ACK;
          next_ack_oe = 1'b1;
          if (is_read) begin
            next_ad_drive = regs[target_addr];
            next_ad_oe = 1'b1;
          end else begin
            next_wr_strobe = 1'b1;
            next_wr_addr = target_addr;
            next_wr_data = ad_s2;
          end
        end
      end
      DEV_ACK: begin
        if (cs_s2 || !strobe_active) begin
          next_state = DEV_IDLE;
          next_ad_oe = 1'b0;
          next_ack_oe = 1'b0;
        end
      end
      default: begin
        next_state = DEV_IDLE;
        next_ad_oe = 1'b0;
        next_ack_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= DEV_IDLE;
      ale_prev <= 1'b0;
      addr_latch <= ADDR_RESET;
      ad_drive <= DATA_RESET;
      ad_oe <= 1'b0;
      ack_oe <= 1'b0;
      irq_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= ADDR_RESET;
      wr_data <= DATA_RESET;
    end else begin
      state <= next_state;
      ale_prev <= next_ale_prev;
      addr_latch <= next_addr_latch;
      ad_drive <= next_ad_drive;
      ad_oe <= next_ad_oe;
      ack_oe <= next_ack_oe;
      irq_oe <= next_irq_oe;
      wr_strobe <= next_wr_strobe;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  // store the written byte into the selected register
  always_ff @(posedge core_clk_in) begin
    if (next_wr_strobe) begin
      regs[next_wr_addr] <= next_wr_data;
    end
  end

  assign bus.dev_ad_out = ad_drive;
  assign bus.dev_ad_oe = ad_oe;
  assign bus.ack_out = 1'b0;
  assign bus.ack_oe = ack_oe;
  assign bus.irq_out = 1'b0;
  assign bus.irq_oe = irq_oe;
  assign wr_strobe_out = wr_strobe;
  assign wr_addr_out = wr_addr;
  assign wr_data_out = wr_data;

endmodule // host_port_device

// >>> host_port_master.sv
// host end: drives register transfers in either bus style
`timescale 1ns/1ns
module host_port_master
  import host_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  host_bus_if.host bus,
  input wire logic style_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic irq_out
);

  logic ack_s1;
  logic ack_s2;
  logic irq_s1;
  logic irq_s2;
  logic [DATA_W-1:0] ad_s1;
  logic [DATA_W-1:0] ad_s2;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
      ad_s1 <= DATA_RESET;
      ad_s2 <= DATA_RESET;
    end else begin
      ack_s1 <= bus.transfer_ack_n;
      ack_s2 <= ack_s1;
      irq_s1 <= bus.irq_request_n;
      irq_s2 <= irq_s1;
      ad_s1 <= bus.ad;
      ad_s2 <= ad_s1;
    end
  end

  host_state_type state;
  host_state_type next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic style;
  logic next_style;
  logic write;
  logic next_write;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] ad_out;
  logic [DATA_W-1:0] next_ad_out;
  logic ad_oe;
  logic next_ad_oe;
  logic ale;
  logic next_ale;
  logic cs_n;
  logic next_cs_n;
  logic ds_n;
  logic next_ds_n;
  logic rw_n;
  logic next_rw_n;
  logic done;
  logic next_done;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_style = style_in;
    next_write = write;
    next_addr = addr;
    next_ad_out = ad_out;
    next_ad_oe = ad_oe;
    next_ale = ale;
    next_cs_n = cs_n;
    next_ds_n = ds_n;
    next_rw_n = rw_n;
    next_done = 1'b0;
    next_rdata = rdata;
    case (state)
      HOST_IDLE: begin
        if (req_in) begin
          next_state = HOST_ADDR;
          next_cnt = SETUP_CYCLES;
          next_write = req_write_in;
          next_addr = req_addr_in;
          if (style == STYLE_MUXED) begin
            next_ale = 1'b1;
            next_addr = {req_addr_in[ADDR_HI], ADDR_RESET[DATA_W-1:0]};
            next_ad_out = req_addr_in[DATA_W-1:0];
            next_ad_oe = 1'b1;
            next_rw_n = 1'b1;
          end else begin
            next_rw_n = ~req_write_in;
            next_ad_out = req_wdata_in;
            next_ad_oe = req_write_in;
          end
          if (req_write_in) begin
            next_rdata = req_wdata_in;
          end
        end
      end
      HOST_ADDR: begin
        next_cnt = cnt - 3'h1;
        if (cnt == CNT_ZERO) begin
          next_cnt = SETUP_CYCLES;
          next_ale = 1'b0;
          next_state = (style == STYLE_MUXED) ? HOST_LATCH : HOST_STROBE;
          next_cs_n = (style == STYLE_MUXED) ? 1'b1 : 1'b0;
          next_ds_n = (style == STYLE_MUXED) ? 1'b1 : 1'b0;
        end
      end
      HOST_LATCH: begin
        next_cnt = cnt - 3'h1;
        if (cnt == CNT_ZERO) begin
          next_state = HOST_STROBE;
          next_cs_n = 1'b0;
          next_ad_out = rdata;
          next_ad_oe = write;
          next_ds_n = write;
          next_rw_n = ~write;
        end
      end
      HOST_STROBE: begin
        if (!ack_s2) begin
          next_state = HOST_RELEASE;
          if (!write) begin
            next_rdata = ad_s2;
          end
          next_cs_n = 1'b1;
          next_ds_n = 1'b1;
          next_rw_n = 1'b1;
        end
      end
      HOST_RELEASE: begin
        next_ad_oe = 1'b0;
        if (ack_s2) begin
          next_state = HOST_IDLE;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= HOST_IDLE;
      cnt <= CNT_ZERO;
      style <= STYLE_SEPARATE;
      write <= 1'b0;
      addr <= ADDR_RESET;
      ad_out <= DATA_RESET;
      ad_oe <= 1'b0;
      ale <= 1'b0;
      cs_n <= 1'b1;
      ds_n <= 1'b1;
      rw_n <= 1'b1;
      done <= 1'b0;
      rdata <= DATA_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      style <= next_style;
      write <= next_write;
      addr <= next_addr;
      ad_out <= next_ad_out;
      ad_oe <= next_ad_oe;
      ale <= next_ale;
      cs_n <= next_cs_n;
      ds_n <= next_ds_n;
      rw_n <= next_rw_n;
      done <= next_done;
      rdata <= next_rdata;
    end
  end

  assign bus.bus_style_select = style;
  assign bus.addr = addr;
  assign bus.host_ad_out = ad_out;
  assign bus.host_ad_oe = ad_oe;
  assign bus.ale = ale;
  assign bus.cs_n = cs_n;
  assign bus.transfer_strobe_n = ds_n;
  assign bus.dir_wr_n = rw_n;
  assign busy_out = (state != HOST_IDLE);
  assign done_out = done;
  assign rdata_out = rdata;
  assign irq_out = ~irq_s2;

endmodule // host_port_master

// >>> host_port_props.sv
// assertion checker on the pins joining host end and device end
`timescale 1ns/1ns
module host_port_props
  import host_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic bus_style_select,
  input wire logic [DATA_W-1:0] ad,
  input wire logic ale,
  input wire logic cs_n,
  input wire logic transfer_strobe_n,
  input wire logic dir_wr_n,
  input wire logic host_ad_oe,
  input wire logic dev_ad_oe,
  input wire logic ack_oe
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_float_on_deselect: assert property (
    cs_n [*5] |-> !ack_oe && !dev_ad_oe) else $error("driven while deselected");
  chk_ack_has_select: assert property (
    $rose(ack_oe) |-> !cs_n && !$past(cs_n, 2)) else $error("ack without select");
  chk_ack_on_transfer: assert property (
    (!cs_n && (!transfer_strobe_n || (bus_style_select && !dir_wr_n))) [*5] |-> ack_oe)
    else $error("no ack for transfer");
  chk_ack_release: assert property (
    $fell(ack_oe) |-> $past(cs_n, 2) ||
    ($past(transfer_strobe_n, 2) && ($past(dir_wr_n, 2) || !bus_style_select)))
    else $error("ack dropped early");
  chk_read_drive: assert property (
    $rose(dev_ad_oe) |-> !$past(transfer_strobe_n, 2) &&
    (bus_style_select || $past(dir_wr_n, 2))) else $error("data driven off read");
  chk_write_no_drive: assert property (
    (!dir_wr_n && (transfer_strobe_n || !bus_style_select)) [*4] |-> !dev_ad_oe)
    else $error("data driven on write");
  chk_no_clash: assert property (
    !(dev_ad_oe && host_ad_oe)) else $error("shared lines contended");
  chk_ale_mux_only: assert property (
    $fell(ale) |-> bus_style_select && cs_n && $stable(ad)) else $error("bad latch strobe");
  cover property ($fell(ale));
  cover property ($rose(dev_ad_oe) && bus_style_select);
  cover property ($rose(ack_oe) && !bus_style_select && !dir_wr_n);
endmodule // host_port_props

// >>> tb_top.sv
// self-checking bench: host end and device end joined over the bus
`timescale 1ns/1ns
module tb_top;
  import host_port_pkg::*;
  logic core_clk_in, rst_in, style_in, req_in, req_write_in, irq_pending_in;
  logic busy_out, done_out, irq_out, wr_strobe_out;
  logic [ADDR_W-1:0] req_addr_in, wr_addr_out;
  logic [DATA_W-1:0] req_wdata_in, rdata_out, wr_data_out;
  logic [DATA_W-1:0] model [REG_DEPTH];
  logic [ADDR_W-1:0] written [$];
  logic [ADDR_W-1:0] corner [4] = '{9'h000, 9'h0ff, 9'h100, 9'h1ff};
  int miscompares = 0;
  int n_compared = 0;
  int n_strobes = 0;
  host_bus_if bus ();
  host_port_device i_host_port_device (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus(bus),
    .irq_pending_in(irq_pending_in), .wr_strobe_out(wr_strobe_out),
    .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out));
  host_port_master i_host_port_master (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus(bus),
    .style_in(style_in), .req_in(req_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .busy_out(busy_out),
    .done_out(done_out), .rdata_out(rdata_out), .irq_out(irq_out));
  host_port_props i_host_port_props (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .bus_style_select(bus.bus_style_select), .ad(bus.ad), .ale(bus.ale), .cs_n(bus.cs_n),
    .transfer_strobe_n(bus.transfer_strobe_n), .dir_wr_n(bus.dir_wr_n),
    .host_ad_oe(bus.host_ad_oe), .dev_ad_oe(bus.dev_ad_oe), .ack_oe(bus.ack_oe));
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) if (wr_strobe_out === 1'b1) n_strobes++;
  function automatic logic [DATA_W-1:0] exp_read(input logic [ADDR_W-1:0] a);
    return model[a];
  endfunction
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (exp !== got) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    int s;
    s = n_strobes;
    @(posedge core_clk_in);
    #1;
    req_write_in = wr;
    req_addr_in = a;
    req_wdata_in = d;
    req_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    req_in = 1'b0;
    check("busy", 9'h1, 9'(busy_out));
    n = 0;
    while (done_out !== 1'b1 && n < 60) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check("done", 9'h1, 9'(n < 60));
    if (wr) begin
      model[a] = d;
      written.push_back(a);
      check("wr_addr", a, wr_addr_out);
      check("wr_data", 9'(d), 9'(wr_data_out));
      check("wr_pulses", 9'(s + 1), 9'(n_strobes));
    end else begin
      check("rdata", 9'(exp_read(a)), 9'(rdata_out));
      check("rd_pulses", 9'(s), 9'(n_strobes));
    end
    check("busy_idle", 9'h0, 9'(busy_out));
    check("ack_idle", 9'h1, 9'(bus.transfer_ack_n));
    check("ad_float", 9'h0, 9'(bus.dev_ad_oe));
  endtask
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    rst_in = 1'b1;
    style_in = 1'b0;
    req_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = 9'h000;
    req_wdata_in = 8'h00;
    irq_pending_in = 1'b0;
    void'($urandom(32'h5173));
    repeat (10) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    for (int st = 0; st < 2; st++) begin
      style_in = st[0];
      repeat (4) @(posedge core_clk_in);
      foreach (corner[i]) xfer(1'b1, corner[i], 8'h5a ^ corner[i][7:0] ^ 8'(st));
      foreach (corner[i]) xfer(1'b0, corner[i], 8'h00);
      repeat (25) begin
        if ($urandom_range(1) == 0) xfer(1'b1, 9'($urandom), 8'($urandom));
        else xfer(1'b0, written[$urandom_range(written.size() - 1)], 8'h00);
      end
    end
    irq_pending_in = 1'b1;
    repeat (8) @(posedge core_clk_in);
    #1;
    check("irq_pin", 9'h0, 9'(bus.irq_request_n));
    check("irq_seen", 9'h1, 9'(irq_out));
    irq_pending_in = 1'b0;
    repeat (8) @(posedge core_clk_in);
    #1;
    check("irq_pin", 9'h1, 9'(bus.irq_request_n));
    check("irq_seen", 9'h0, 9'(irq_out));
    finish_test();
  end
endmodule // tb_top
